// [inc/cob_pkg.sv]
// Constants and types for the clock output enable control block
package cob_pkg;

  localparam int unsigned CLK_NS = 10;
  localparam int unsigned LOCK_US = 100;
  localparam int unsigned LOCK_CYC = LOCK_US * 1000 / CLK_NS;
  localparam int unsigned MIN_FREQ_MHZ = 20;
  localparam int unsigned MIN_PERIOD_NS = 1000 / MIN_FREQ_MHZ;
  localparam logic [7:0] SLOW_CYC = 8'(MIN_PERIOD_NS / CLK_NS);
  localparam logic [7:0] PER_MAX = 8'hFF;

  localparam int unsigned NPAIR = 10;
  localparam int unsigned LO_PAIRS = 8;
  localparam int unsigned HI_PAIR8_BIT = 7;
  localparam int unsigned HI_PAIR9_BIT = 6;
  localparam int unsigned LEAK_BIT = 7;

  localparam logic [1:0] IDX_LO = 2'h0;
  localparam logic [1:0] IDX_HI = 2'h1;
  localparam logic [1:0] IDX_TEST = 2'h2;
  localparam logic [1:0] IDX_END = 2'h3;

  localparam logic [7:0] OE_LO_RST = 8'hFF;
  localparam logic [7:0] OE_HI_RST = 8'hC0;
  localparam logic [7:0] OE_HI_MASK = 8'hC0;
  localparam logic [7:0] TEST_RST = 8'hFF;

  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;
  // Bus address value is arbitrary
  localparam logic [6:0] SLAVE_ADDR = 7'h5A;

  typedef enum logic [4:0] {
    SS_IDLE = 5'h01,
    SS_ADDR = 5'h02,
    SS_CMD = 5'h04,
    SS_CNT = 5'h08,
    SS_DATA = 5'h10
  } cob_ss_t;

endpackage : cob_pkg

// [hw/cob_serial_slave.sv]
// Two-line serial bus write slave: address, command, count, data bytes
`timescale 1ns/1ps
module cob_serial_slave #(
  parameter logic [6:0] ADDR = cob_pkg::SLAVE_ADDR
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic scl_pin,
  input wire logic sda_pin,
  output logic sda_oe,
  output logic wr_stb,
  output logic [1:0] wr_idx,
  output logic [7:0] wr_data
);
  import cob_pkg::*;

  logic [2:0] scl_r;
  logic [2:0] sda_r;
  logic scl_s, scl_p, sda_s, sda_p;
  logic start, stop, rise, fall;
  logic [7:0] byte_w;
  cob_ss_t state_q;
  logic [3:0] bit_q;
  logic [6:0] sh_q;
  logic [1:0] ptr_q;
  logic [7:0] cnt_q;
  logic ack_want_q;

  ////////////////////////////////////////////////////////////////////////
  // Bus idles high, so the synchronisers reset high
  always_ff @(posedge clk) begin
    if (rst) begin
      scl_r <= '1;
      sda_r <= '1;
    end else begin
      scl_r <= {scl_r[1:0], scl_pin};
      sda_r <= {sda_r[1:0], sda_pin};
    end
  end

  assign scl_s = scl_r[1];
  assign scl_p = scl_r[2];
  assign sda_s = sda_r[1];
  assign sda_p = sda_r[2];
  assign start = scl_s & scl_p & sda_p & ~sda_s;
  assign stop = scl_s & scl_p & ~sda_p & sda_s;
  assign rise = scl_s & ~scl_p;
  assign fall = ~scl_s & scl_p;
  assign byte_w = {sh_q, sda_s};

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= SS_IDLE;
      bit_q <= '0;
      sh_q <= '0;
      ptr_q <= IDX_LO;
      cnt_q <= '0;
      ack_want_q <= 1'b0;
      wr_stb <= 1'b0;
      wr_idx <= IDX_LO;
      wr_data <= '0;
    end else begin
      wr_stb <= 1'b0;
      if (start) begin
        state_q <= SS_ADDR;
        bit_q <= '0;
        ack_want_q <= 1'b0;
      end else if (stop) begin
        state_q <= SS_IDLE;
      end else if (rise && state_q != SS_IDLE) begin
        if (bit_q == BIT_ACK) begin
          bit_q <= '0;
        end else begin
          sh_q <= byte_w[6:0];
          bit_q <= bit_q + 4'h1;
        end
        if (bit_q == BIT_LAST) begin
          ack_want_q <= 1'b0;
          case (state_q)
            SS_ADDR: begin
              // Reads are not supported, only a write address is answered
              if (byte_w == {ADDR, 1'b0}) begin
                state_q <= SS_CMD;
                ack_want_q <= 1'b1;
              end else begin
                state_q <= SS_IDLE;
              end
            end
            SS_CMD: begin
              ptr_q <= byte_w[1:0];
              ack_want_q <= 1'b1;
              state_q <= SS_CNT;
            end
            SS_CNT: begin
              cnt_q <= byte_w;
              ack_want_q <= 1'b1;
              state_q <= SS_DATA;
            end
            SS_DATA: begin
              // Bytes beyond the count are not acknowledged
              if (cnt_q != '0) begin
                cnt_q <= cnt_q - 8'h01;
                ack_want_q <= 1'b1;
                if (ptr_q != IDX_END) begin
                  wr_stb <= 1'b1;
                  wr_idx <= ptr_q;
                  wr_data <= byte_w;
                  ptr_q <= ptr_q + 2'h1;
                end
              end
            end
            default: state_q <= SS_IDLE;
          endcase
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Acknowledge is driven low from the eighth falling edge to the ninth
  always_ff @(posedge clk) begin
    if (rst) begin
      sda_oe <= 1'b0;
    end else if (start || stop) begin
      sda_oe <= 1'b0;
    end else if (fall) begin
      sda_oe <= (bit_q == BIT_ACK) & ack_want_q;
    end
  end

endmodule : cob_serial_slave

// [hw/cob_out_enable_ctrl.sv]
// Output enable control of a ten-pair differential clock buffer
`timescale 1ns/1ps
module cob_out_enable_ctrl #(
  parameter int unsigned LOCK_CYCLES = cob_pkg::LOCK_CYC,
  parameter logic [6:0] BUS_ADDR = cob_pkg::SLAVE_ADDR
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic reference_clock_in,
  input wire logic pll_supply_bypass_strap,
  input wire logic serial_bus_clock,
  input wire logic serial_bus_data_in,
  output logic serial_bus_data_out,
  output logic serial_bus_data_oe,
  output logic [cob_pkg::NPAIR-1:0] true_clock_out,
  output logic [cob_pkg::NPAIR-1:0] true_clock_oe,
  output logic [cob_pkg::NPAIR-1:0] complement_clock_out,
  output logic [cob_pkg::NPAIR-1:0] complement_clock_oe,
  output logic feedback_clock_out,
  output logic feedback_clock_oe,
  output logic pll_locked,
  output logic pll_leak_test
);
  import cob_pkg::*;

  localparam int unsigned LW = $clog2(LOCK_CYCLES + 1);
  localparam logic [LW-1:0] LOCK_LAST = LW'(LOCK_CYCLES - 1);

  logic [2:0] ref_r;
  logic [1:0] strap_r;
  logic ref_s, ref_p, ref_rise, bypass;
  logic wr_stb;
  logic [1:0] wr_idx;
  logic [7:0] wr_data;
  logic [7:0] oe_lo_q;
  logic [7:0] oe_hi_q;
  logic [7:0] test_q;
  logic [NPAIR-1:0] en_vec;
  logic [7:0] per_q;
  logic slow_q;
  logic pll_on, drive, lvl_d;
  logic [LW-1:0] lock_q;
  logic locked_q;
  logic [NPAIR-1:0] true_q;
  logic [NPAIR-1:0] comp_q;
  logic [NPAIR-1:0] oe_q;
  logic fb_q;
  logic fb_oe_q;
  logic leak_q;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; third stage of the clock feeds the edge detector
  always_ff @(posedge clk) begin
    if (rst) begin
      ref_r <= '0;
      strap_r <= '1;
    end else begin
      ref_r <= {ref_r[1:0], reference_clock_in};
      strap_r <= {strap_r[0], pll_supply_bypass_strap};
    end
  end

  assign ref_s = ref_r[1];
  assign ref_p = ref_r[2];
  assign ref_rise = ref_s & ~ref_p;
  assign bypass = ~strap_r[1];

  ////////////////////////////////////////////////////////////////////////
  cob_serial_slave #(
    .ADDR(BUS_ADDR)
  ) u_slave (
    .clk(clk),
    .rst(rst),
    .scl_pin(serial_bus_clock),
    .sda_pin(serial_bus_data_in),
    .sda_oe(serial_bus_data_oe),
    .wr_stb(wr_stb),
    .wr_idx(wr_idx),
    .wr_data(wr_data)
  );

  // Open-drain line: only ever pulled low
  assign serial_bus_data_out = 1'b0;

  ////////////////////////////////////////////////////////////////////////
  // Serial registers; reset stands for power-up
  always_ff @(posedge clk) begin
    if (rst) begin
      oe_lo_q <= OE_LO_RST;
      oe_hi_q <= OE_HI_RST;
      test_q <= TEST_RST;
    end else if (wr_stb) begin
      case (wr_idx)
        IDX_LO: oe_lo_q <= wr_data;
        IDX_HI: oe_hi_q <= wr_data & OE_HI_MASK;
        IDX_TEST: test_q <= wr_data;
        default: ;
      endcase
    end
  end

  always_comb begin
    en_vec = '0;
    for (int i = 0; i < LO_PAIRS; i++) begin
      en_vec[i] = oe_lo_q[LO_PAIRS-1-i];
    end
    en_vec[LO_PAIRS] = oe_hi_q[HI_PAIR8_BIT];
    en_vec[LO_PAIRS+1] = oe_hi_q[HI_PAIR9_BIT];
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      leak_q <= 1'b0;
    end else begin
      leak_q <= ~test_q[LEAK_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Input frequency watch: too long since the last rising edge means slow
  always_ff @(posedge clk) begin
    if (rst) begin
      per_q <= '0;
      slow_q <= 1'b1;
    end else if (ref_rise) begin
      per_q <= '0;
      if (per_q < SLOW_CYC) begin
        slow_q <= 1'b0;
      end
    end else begin
      if (per_q != PER_MAX) begin
        per_q <= per_q + 8'h01;
      end
      if (per_q >= SLOW_CYC) begin
        slow_q <= 1'b1;
      end
    end
  end

  assign pll_on = ~bypass & ~slow_q;
  assign drive = bypass | ~slow_q;

  ////////////////////////////////////////////////////////////////////////
  // Lock model: the loop counts as locked a fixed time after it powers on
  always_ff @(posedge clk) begin
    if (rst || !pll_on) begin
      lock_q <= '0;
      locked_q <= 1'b0;
    end else if (lock_q == LOCK_LAST) begin
      locked_q <= 1'b1;
    end else begin
      lock_q <= lock_q + LW'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Unless bypassed, true and feedback outputs stay low and complements high until lock, so no pulse leaves before the loop settles
  assign lvl_d = ref_s & (bypass | locked_q);

  always_ff @(posedge clk) begin
    if (rst) begin
      true_q <= '0;
      comp_q <= '0;
      fb_q <= 1'b0;
    end else begin
      true_q <= {NPAIR{lvl_d}};
      comp_q <= {NPAIR{~lvl_d}};
      fb_q <= lvl_d;
    end
  end

  // Pair enables move only on a low-phase sample, the feedback enable follows drive on any phase; unless bypassed, a slow input kills them at once
  always_ff @(posedge clk) begin
    if (rst) begin
      oe_q <= '0;
      fb_oe_q <= 1'b0;
    end else begin
      fb_oe_q <= drive;
      if (!drive) begin
        oe_q <= '0;
      end else if (!ref_s) begin
        oe_q <= en_vec;
      end
    end
  end

  assign true_clock_out = true_q;
  assign complement_clock_out = comp_q;
  assign true_clock_oe = oe_q;
  assign complement_clock_oe = oe_q;
  assign feedback_clock_out = fb_q;
  assign feedback_clock_oe = fb_oe_q;
  assign pll_locked = locked_q;
  assign pll_leak_test = leak_q;

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_write_lo;
    wr_stb && wr_idx == IDX_LO;
  endsequence

  a_pair_disable: assert property (!en_vec[0] && !ref_s && drive |=> !true_clock_oe[0])
    else $error("pair 0 not three-stated after its enable bit cleared");

  a_fb_driven: assert property (!slow_q || bypass |=> feedback_clock_oe)
    else $error("feedback output not driven");

  a_no_runt: assert property ($past(drive) && drive |-> ((oe_q ^ $past(oe_q)) & true_q) == '0)
    else $error("pair enable changed while its clock was high");

  a_lo_reset: assert property ($past(rst) |-> oe_lo_q == OE_LO_RST && oe_hi_q == OE_HI_RST)
    else $error("enable registers wrong after reset");

  a_hi_reserved: assert property (s_write_lo or wr_stb |=> oe_hi_q[5:0] == '0)
    else $error("reserved enable bits not zero");

  a_leak_sel: assert property ($past(rst) |-> test_q == TEST_RST ##1 !pll_leak_test)
    else $error("test register reset or leak select wrong");

  a_bypass_follow: assert property (bypass |=> true_clock_out[0] == $past(ref_s)
    && complement_clock_out[0] == !$past(ref_s) && feedback_clock_out == $past(ref_s))
    else $error("bypass outputs do not follow the input clock");

  a_lock_time: assert property ($rose(locked_q) |-> $past(lock_q) == LOCK_LAST && $past(pll_on))
    else $error("lock flag not tied to lock time");

  a_slow_hiz: assert property (slow_q && !bypass |=> oe_q == '0 && !fb_oe_q ##0 !locked_q)
    else $error("outputs not three-stated with slow input");

  a_write_seq: assert property (s_write_lo |=> oe_lo_q == $past(wr_data))
    else $error("data byte not written to the low enable register");

endmodule : cob_out_enable_ctrl

// [sim/cob_bus_master.sv]
// Serial bus master model driving the two-line control bus
`timescale 1ns/1ps
module cob_bus_master (
  input wire logic clk,
  input wire logic sda_wire,
  output logic scl,
  output logic sda_low
);
  // Bus idles released; pull-ups hold both lines high
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  task automatic start();
    sda_low <= 1'b1;
    tick(4);
  endtask : start

  // Data moves only mid low phase, so never a false start or stop
  task automatic put_bit(input logic b);
    scl <= 1'b0;
    tick(2);
    sda_low <= ~b;
    tick(2);
    scl <= 1'b1;
    tick(4);
  endtask : put_bit

  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      put_bit(b[i]);
    end
    scl <= 1'b0;
    tick(2);
    sda_low <= 1'b0;
    tick(2);
    scl <= 1'b1;
    tick(3);
    ack = ~sda_wire;
    tick(1);
  endtask : send_byte

  task automatic stop();
    scl <= 1'b0;
    tick(2);
    sda_low <= 1'b1;
    tick(2);
    scl <= 1'b1;
    tick(4);
    sda_low <= 1'b0;
    tick(8);
  endtask : stop
endmodule : cob_bus_master

// [sim/testbench.sv]
// Self-checking testbench of the clock output enable control block
`timescale 1ns/1ps
module testbench;
  import cob_pkg::*;
  localparam int unsigned LOCK_SIM = 20;
  localparam int LIMIT = 20000;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic strap = 1'b0;
  logic [1:0] ref_mode = 2'h1;
  logic slow_ref = 1'b0;
  logic fast_ref = 1'b0;
  logic [1:0] slow_cnt = 2'h0;
  logic [2:0] ref_pipe = 3'h0;
  logic ref_clk, scl, sda_low, sda_wire, sda_out, sda_oe, fb_out, fb_oe, locked, leak;
  logic [NPAIR-1:0] t_out, t_oe, c_out, c_oe, oe_prev;
  int failures = 0;
  int checked = 0;
  int cycles = 0;
  int n;

  always #5 clk = ~clk;
  always #4 fast_ref = ~fast_ref;
  // Bypass clock is 25 MHz; PLL is off then, so no frequency floor
  always @(posedge clk) begin
    slow_cnt <= slow_cnt + 2'h1;
    if (slow_cnt[0]) begin
      slow_ref <= ~slow_ref;
    end
  end
  assign ref_clk = (ref_mode == 2'h2) ? fast_ref : (ref_mode == 2'h1) ? slow_ref : 1'b0;
  assign sda_wire = !(sda_low || (sda_oe && !sda_out));

  cob_out_enable_ctrl #(.LOCK_CYCLES(LOCK_SIM)) DUT (
    .clk(clk), .rst(rst), .reference_clock_in(ref_clk), .pll_supply_bypass_strap(strap),
    .serial_bus_clock(scl), .serial_bus_data_in(sda_wire), .serial_bus_data_out(sda_out),
    .serial_bus_data_oe(sda_oe), .true_clock_out(t_out), .true_clock_oe(t_oe),
    .complement_clock_out(c_out), .complement_clock_oe(c_oe), .feedback_clock_out(fb_out),
    .feedback_clock_oe(fb_oe), .pll_locked(locked), .pll_leak_test(leak)
  );
  cob_bus_master M (.clk(clk), .sda_wire(sda_wire), .scl(scl), .sda_low(sda_low));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic fail(input string msg);
    failures++;
    $display("wrong value at %0t: %s", $time, msg);
  endtask : fail

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checked++;
    if (got !== exp) begin
      fail(msg);
    end
  endtask : chk

  task automatic print_verdict();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : print_verdict

  task automatic settle(input int k, input string name);
    repeat (k) @(negedge clk);
    $display("test %s done", name);
  endtask : settle

  // Outputs lag the input by the two sync stages plus one register
  task automatic check_follow(input int k);
    repeat (k) begin
      @(negedge clk);
      chk(fb_out, ref_pipe[2], "feedback not following input");
      chk(t_out, {NPAIR{ref_pipe[2]}}, "true output not following");
      chk(c_out, {NPAIR{~ref_pipe[2]}}, "complement not inverted");
    end
  endtask : check_follow

  task automatic write_regs(input logic [6:0] adr, input logic [7:0] cmd, input logic [7:0] cnt,
      input logic [7:0] data [$]);
    logic ack;
    // Bus lines only move just after a rising edge
    @(posedge clk);
    M.start();
    M.send_byte({adr, 1'b0}, ack);
    chk(ack, 32'(adr == SLAVE_ADDR), "address acknowledge");
    if (ack) begin
      M.send_byte(cmd, ack);
      chk(ack, 1, "command acknowledge");
      M.send_byte(cnt, ack);
      chk(ack, 1, "count acknowledge");
      foreach (data[i]) begin
        M.send_byte(data[i], ack);
        chk(ack, 32'(i < cnt), "data acknowledge");
      end
    end
    M.stop();
  endtask : write_regs

  ////////////////////////////////////////////////////////////////////////////////
  // Runt watch: a pair whose enable just moved must be showing low
  always @(posedge clk) begin
    ref_pipe <= {ref_pipe[1:0], ref_clk};
    oe_prev <= t_oe;
    cycles <= cycles + 1;
    if (cycles > 40 && !strap && ((oe_prev ^ t_oe) & t_out) != '0) begin
      fail("enable changed while output high");
    end
    if (cycles == LIMIT) begin
      fail("timeout");
      print_verdict();
    end
  end

  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    settle(30, "reset");
    chk(t_oe, 10'h3FF, "enables after reset");
    chk(leak, 0, "leak test after reset");
    chk(fb_oe, 1, "feedback enable after reset");
    check_follow(12);
    write_regs(SLAVE_ADDR, 8'h00, 8'h01, '{8'h0F});
    settle(10, "low register");
    chk(t_oe, 10'h3F0, "low register enables");
    chk(c_oe, 10'h3F0, "complement enables");
    check_follow(12);
    write_regs(SLAVE_ADDR, 8'h00, 8'h03, '{8'hFF, 8'h40, 8'h7F, 8'h00});
    settle(10, "burst");
    chk(t_oe, 10'h2FF, "burst enables");
    chk(leak, 1, "leak test selected");
    chk(fb_oe, 1, "feedback still driven");
    write_regs(SLAVE_ADDR, 8'h01, 8'h02, '{8'h80, 8'h00});
    write_regs(SLAVE_ADDR, 8'h02, 8'h01, '{8'h80});
    settle(10, "start index");
    chk(t_oe, 10'h1FF, "high register enables");
    chk(leak, 0, "leak test released");
    write_regs(SLAVE_ADDR ^ 7'h01, 8'h00, 8'h01, '{8'h00});
    settle(10, "foreign address");
    chk(t_oe, 10'h1FF, "foreign write ignored");
    write_regs(SLAVE_ADDR, 8'h03, 8'h01, '{8'h00});
    settle(10, "index past test register");
    chk(t_oe, 10'h1FF, "write past last register landed");
    chk(leak, 0, "test register changed by index three");
    @(posedge clk);
    strap <= 1'b1;
    ref_mode <= 2'h2;
    n = 0;
    while (locked !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    chk(32'(n <= LOCK_SIM + 20), 1, "lock too late");
    settle(4, "lock");
    chk(t_oe, 10'h1FF, "enables after lock");
    chk(fb_oe, 1, "feedback after lock");
    check_follow(8);
    @(posedge clk);
    ref_mode <= 2'h0;
    settle(12, "input lost");
    chk(t_oe, 10'h000, "true outputs not floated");
    chk(c_oe, 10'h000, "complement outputs not floated");
    chk(fb_oe, 0, "feedback not floated");
    chk(locked, 0, "lock not dropped");
    print_verdict();
  end
endmodule : testbench
